//--- rtl/siosad_top.sv
// Short I/O slave address and access-mode decoder with its register window.
// Assumes address, modifier, strobe and data inputs are synchronous to sys_clk_i.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Claim only short accesses whose A15..A07 equal the nine jumper base bits.
// - A fitted address jumper counts as zero, an absent one as one.
// - Six address lines below the base select the register inside the window.
// - Factory jumpers give base zero and supervisory short access.
// - Privilege jumper absent selects supervisory, fitted selects nonprivileged access.
// - Output channel words sit at even offsets 0x40 through 0x7e.
// - The window holds 64 contiguous 16-bit locations relative to the base.
// - Control and status word sits at offset 0x02.
module siosad_top (
  input  wire logic                             sys_clk_i,
  input  wire logic                             reset_n_i,
  input  wire logic [siosad_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic [siosad_pkg::AM_W-1:0]      am_i,
  input  wire logic                             strobe_i,
  input  wire logic                             write_i,
  input  wire logic [siosad_pkg::DATA_W-1:0]    wdata_i,
  input  wire logic [siosad_pkg::UPPER_W-1:0]   upper_base_address_jumpers_i,
  input  wire logic                             low_base_address_jumper_i,
  input  wire logic                             privilege_select_jumper_i,
  input  wire logic [siosad_pkg::DATA_W-1:0]    adc_data_i,
  output logic      [siosad_pkg::DATA_W-1:0]    rdata_o,
  output logic                                  data_oe_n_o,
  output logic                                  ack_o,
  output logic      [siosad_pkg::DATA_W-1:0]    control_status_word_o
);
  typedef enum logic [1:0] {SIOSAD_IDLE, SIOSAD_ACK, SIOSAD_WAIT} siosad_state_t;

  siosad_state_t                      state_q;
  logic [siosad_pkg::BASE_W-1:0]      base;
  logic                               base_match;
  logic                               am_match;
  logic                               claim;
  logic                               rd_q;
  logic [siosad_pkg::DATA_W-1:0]      regs_rdata;

  siosad_dec_if dec ();

  // ----------------------------------------------------------------
  // Address and modifier compare
  // ----------------------------------------------------------------
  // Jumper inputs are the raw pin level: fitted reads low, so no inversion needed
  assign base       = {upper_base_address_jumpers_i, low_base_address_jumper_i};
  assign base_match = (addr_i[siosad_pkg::BASE_MSB:siosad_pkg::BASE_LSB] == base);
  // Fitted privilege jumper means nonprivileged; absent gives the factory supervisory mode
  assign am_match   = (privilege_select_jumper_i == siosad_pkg::JUMPER_FITTED) ?
                      (am_i == siosad_pkg::AM_SHORT_NONPRV) :
                      (am_i == siosad_pkg::AM_SHORT_SUPER);
  assign claim      = strobe_i && base_match && am_match && (state_q == SIOSAD_IDLE);

  assign dec.hit   = claim;
  assign dec.wr    = write_i;
  assign dec.idx   = addr_i[siosad_pkg::REG_IDX_LSB +: siosad_pkg::REG_IDX_W];
  assign dec.wdata = wdata_i;

  siosad_regs u_regs (
    .sys_clk_i  (sys_clk_i),
    .reset_n_i  (reset_n_i),
    .acc        (dec),
    .adc_data_i (adc_data_i),
    .rdata_o    (regs_rdata),
    .ctrl_o     (control_status_word_o)
  );

  // ----------------------------------------------------------------
  // Cycle sequencer: one acknowledge per claimed strobe
  // ----------------------------------------------------------------
  // Waiting for strobe release keeps a long master strobe from double writing
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state_q <= SIOSAD_IDLE;
    end else begin
      case (state_q)
        SIOSAD_IDLE: if (claim) state_q <= SIOSAD_ACK;
        SIOSAD_ACK:  state_q <= strobe_i ? SIOSAD_WAIT : SIOSAD_IDLE;
        SIOSAD_WAIT: if (!strobe_i) state_q <= SIOSAD_IDLE;
        default:     state_q <= SIOSAD_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      rd_q <= 1'b0;
    end else if (claim) begin
      rd_q <= !write_i;
    end else if (state_q != SIOSAD_IDLE && !strobe_i) begin
      rd_q <= 1'b0;
    end
  end

  assign ack_o       = (state_q == SIOSAD_ACK);
  assign data_oe_n_o = !(rd_q && state_q != SIOSAD_IDLE);
  assign rdata_o     = regs_rdata;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Reference values built apart from the decode path above
  logic [siosad_pkg::BASE_W-1:0] chk_jumpers;
  logic [siosad_pkg::BASE_W-1:0] chk_addr_base;
  logic [6:0]                    chk_ofs;
  logic                          chk_reserved;
  logic                          chk_factory;

  assign chk_jumpers   = {upper_base_address_jumpers_i, low_base_address_jumper_i};
  assign chk_addr_base = addr_i[siosad_pkg::BASE_MSB:siosad_pkg::BASE_LSB];
  // Bit 0 of the byte address never selects a register
  assign chk_ofs       = {addr_i[siosad_pkg::REG_IDX_LSB +: siosad_pkg::REG_IDX_W], 1'b0};
  assign chk_reserved  = (chk_ofs > siosad_pkg::OFS_ADC) && (chk_ofs < siosad_pkg::OFS_CHAN_FIRST);
  assign chk_factory   = (chk_jumpers == {siosad_pkg::BASE_W{siosad_pkg::JUMPER_FITTED}})
                         && (privilege_select_jumper_i != siosad_pkg::JUMPER_FITTED);

  sequence s_claim;
    strobe_i && base_match && am_match && state_q == SIOSAD_IDLE;
  endsequence
  sequence s_read_claim;
    s_claim ##0 !write_i;
  endsequence
  sequence s_write_claim;
    s_claim ##0 write_i;
  endsequence
  // Read answer: acknowledge with the data lines driven
  sequence s_read_answer;
    ack_o && !data_oe_n_o;
  endsequence


  AST_ACK_AFTER_CLAIM: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    s_claim |=> ack_o)
    else $error("claimed cycle not acknowledged");
  AST_NO_ACK_ON_MISS: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (state_q == SIOSAD_IDLE && !(strobe_i && base_match && am_match)) |=> !ack_o)
    else $error("acknowledge without a match");
  // A fitted jumper refuses a one on its line, an absent one refuses a zero
  AST_BASE_COMPARE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    base_match == (((chk_addr_base & ~chk_jumpers) | (~chk_addr_base & chk_jumpers))
                   == {siosad_pkg::BASE_W{1'b0}}))
    else $error("base compare wrong");
  AST_FACTORY_BASE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (chk_factory && strobe_i && chk_addr_base == {siosad_pkg::BASE_W{1'b0}}
     && am_i == siosad_pkg::AM_SHORT_SUPER && state_q == SIOSAD_IDLE) |=> ack_o)
    else $error("factory setting not answered");
  AST_FACTORY_NONPRV: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (chk_factory && strobe_i && am_i == siosad_pkg::AM_SHORT_NONPRV) |=> !ack_o)
    else $error("factory setting answered a nonprivileged cycle");
  AST_PRIV_SELECT: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    am_match |-> (privilege_select_jumper_i != siosad_pkg::JUMPER_FITTED ?
                  am_i == siosad_pkg::AM_SHORT_SUPER : am_i == siosad_pkg::AM_SHORT_NONPRV))
    else $error("modifier select wrong");
  AST_NONPRV_REFUSES_SUPER: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (privilege_select_jumper_i == siosad_pkg::JUMPER_FITTED
     && am_i == siosad_pkg::AM_SHORT_SUPER) |-> !claim)
    else $error("supervisory cycle claimed with the jumper fitted");
  AST_ONE_ACK: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");
  AST_NO_DRIVE_IDLE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    state_q == SIOSAD_IDLE |-> data_oe_n_o)
    else $error("data driven outside a claimed cycle");
  AST_READ_DRIVES: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (s_claim and !write_i) |=> !data_oe_n_o && ack_o)
    else $error("claimed read not driven");
  AST_CTRL_WRITE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (s_write_claim ##0 chk_ofs == siosad_pkg::OFS_CTRL) |=> control_status_word_o == $past(wdata_i))
    else $error("control word not written");
  AST_CTRL_KEEP: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !(claim && write_i && chk_ofs == siosad_pkg::OFS_CTRL) |=> $stable(control_status_word_o))
    else $error("control word changed without a claimed write");

  // ----------------------------------------------------------------
  // Reset and cycle framing checks
  // ----------------------------------------------------------------
  // No disable here: the reset itself is what this one watches
  AST_RESET_STATE: assert property (@(posedge sys_clk_i)
    !reset_n_i |=> !ack_o && data_oe_n_o && rdata_o == siosad_pkg::DATA_ZERO
                   && control_status_word_o == siosad_pkg::DATA_ZERO)
    else $error("outputs not cleared by reset");
  AST_ACK_NEEDS_CLAIM: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    ack_o |-> $past(claim))
    else $error("acknowledge without a claim");
  AST_WINDOW_ANY_OFFSET: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (strobe_i && am_match && state_q == SIOSAD_IDLE && chk_addr_base == chk_jumpers) |-> claim)
    else $error("offset inside the window not claimed");
  AST_DROP_ENDS_CYCLE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (state_q != SIOSAD_IDLE && !strobe_i) |=> state_q == SIOSAD_IDLE)
    else $error("cycle not closed after strobe release");
  AST_WRITE_NO_DRIVE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    s_write_claim |=> ack_o && data_oe_n_o && $stable(rdata_o))
    else $error("write answered with driven data");

  // ----------------------------------------------------------------
  // Read path checks
  // ----------------------------------------------------------------
  // Data must stand for as long as the master keeps its strobe up
  AST_READ_HOLD: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (!data_oe_n_o && strobe_i) |=> !data_oe_n_o)
    else $error("read data released under a held strobe");
  AST_READ_RELEASE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (!data_oe_n_o && !strobe_i) |=> data_oe_n_o)
    else $error("read data still driven after strobe release");
  AST_RDATA_STABLE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (!data_oe_n_o && !ack_o) |-> $stable(rdata_o))
    else $error("read data moved while driven");
  AST_ID_READ: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (s_read_claim ##0 chk_ofs == siosad_pkg::OFS_BOARD_ID) |=> s_read_answer ##0 rdata_o == siosad_pkg::BOARD_ID_VAL)
    else $error("identification word wrong");
  AST_ADC_READ: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (s_read_claim ##0 chk_ofs == siosad_pkg::OFS_ADC) |=> s_read_answer ##0 rdata_o == $past(adc_data_i))
    else $error("converter word wrong");
  AST_CTRL_READ: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (s_read_claim ##0 chk_ofs == siosad_pkg::OFS_CTRL) |=> rdata_o == $past(control_status_word_o))
    else $error("control word readback wrong");
  AST_RESERVED_READ: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (s_read_claim ##0 chk_reserved) |=> s_read_answer ##0 rdata_o == siosad_pkg::DATA_ZERO)
    else $error("reserved word not zero");
endmodule : siosad_top
`default_nettype wire

//--- rtl/siosad_pkg.sv
// Package of constants for the short I/O slave address decoder.
// Assumes a 16-bit short address space with byte addressing on the backplane.
package siosad_pkg;
  // ----------------------------------------------------------------
  // Address layout
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W       = 16;
  localparam int unsigned BASE_W       = 9;
  localparam int unsigned BASE_LSB     = 7;
  localparam int unsigned BASE_MSB     = 15;
  localparam int unsigned UPPER_W      = 8;
  localparam int unsigned REG_IDX_W    = 6;
  localparam int unsigned REG_IDX_LSB  = 1;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned AM_W         = 6;
  localparam int unsigned AM_PRIV_BIT  = 2;
  localparam int unsigned NUM_CHAN     = 32;
  localparam int unsigned CHAN_W       = 5;

  // ----------------------------------------------------------------
  // Register offsets (byte offsets within the window)
  // ----------------------------------------------------------------
  localparam logic [6:0] OFS_BOARD_ID  = 7'h00;
  localparam logic [6:0] OFS_CTRL      = 7'h02;
  localparam logic [6:0] OFS_ADC       = 7'h04;
  localparam logic [6:0] OFS_CHAN_FIRST = 7'h40;
  localparam logic [6:0] OFS_CHAN_LAST  = 7'h7e;

  // ----------------------------------------------------------------
  // Address modifier codes for short I/O
  // ----------------------------------------------------------------
  localparam logic [AM_W-1:0] AM_SHORT_SUPER  = 6'h2d;
  localparam logic [AM_W-1:0] AM_SHORT_NONPRV = 6'h29;

  // Jumper sense: fitted pulls low
  localparam logic JUMPER_FITTED = 1'b0;

  // Board identification word, value arbitrary
  localparam logic [DATA_W-1:0] BOARD_ID_VAL = 16'h5a00;

  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
  localparam logic [CHAN_W-1:0] CHAN_ZERO = 5'h00;
endpackage : siosad_pkg

//--- rtl/siosad_dec_if.sv
// Interface carrying the decoded access from the decoder to the register file.
// Assumes a single clock shared by both ends.
`timescale 1ns/100ps
`default_nettype none
interface siosad_dec_if;
  logic                                   hit;
  logic                                   wr;
  logic [siosad_pkg::REG_IDX_W-1:0]       idx;
  logic [siosad_pkg::DATA_W-1:0]          wdata;
  modport dec (output hit, output wr, output idx, output wdata);
  modport regs (input hit, input wr, input idx, input wdata);
endinterface : siosad_dec_if
`default_nettype wire

//--- rtl/siosad_regs.sv
// Register file behind the decoded window: control word and output channel words.
// Assumes decoded strobes arrive one per accepted cycle from the decoder.
`timescale 1ns/100ps
`default_nettype none
module siosad_regs (
  input  wire logic                          sys_clk_i,
  input  wire logic                          reset_n_i,
  siosad_dec_if.regs                         acc,
  input  wire logic [siosad_pkg::DATA_W-1:0] adc_data_i,
  output logic      [siosad_pkg::DATA_W-1:0] rdata_o,
  output logic      [siosad_pkg::DATA_W-1:0] ctrl_o
);
  logic [siosad_pkg::DATA_W-1:0] chan_q [siosad_pkg::NUM_CHAN];
  logic [siosad_pkg::DATA_W-1:0] ctrl_q;
  logic [siosad_pkg::DATA_W-1:0] rdata_d;
  logic [6:0]                    ofs;
  logic                          is_chan;
  logic [siosad_pkg::CHAN_W-1:0] chan_sel;

  assign ofs      = {acc.idx, 1'b0};
  assign is_chan  = (ofs >= siosad_pkg::OFS_CHAN_FIRST) && (ofs <= siosad_pkg::OFS_CHAN_LAST);
  assign chan_sel = acc.idx[siosad_pkg::CHAN_W-1:0];

  // ----------------------------------------------------------------
  // Writes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ctrl_q <= siosad_pkg::DATA_ZERO;
    end else if (acc.hit && acc.wr && ofs == siosad_pkg::OFS_CTRL) begin
      ctrl_q <= acc.wdata;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < siosad_pkg::NUM_CHAN; i++) begin
        chan_q[i] <= siosad_pkg::DATA_ZERO;
      end
    end else if (acc.hit && acc.wr && is_chan) begin
      chan_q[chan_sel] <= acc.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read mux; reserved offsets read zero
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = siosad_pkg::DATA_ZERO;
    if (is_chan) begin
      rdata_d = chan_q[chan_sel];
    end else begin
      case (ofs)
        siosad_pkg::OFS_BOARD_ID: rdata_d = siosad_pkg::BOARD_ID_VAL;
        siosad_pkg::OFS_CTRL:     rdata_d = ctrl_q;
        siosad_pkg::OFS_ADC:      rdata_d = adc_data_i;
        default:                  rdata_d = siosad_pkg::DATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      rdata_o <= siosad_pkg::DATA_ZERO;
    end else if (acc.hit && !acc.wr) begin
      rdata_o <= rdata_d;
    end
  end

  assign ctrl_o = ctrl_q;
endmodule : siosad_regs
`default_nettype wire

//--- sim/siosad_host_model.sv
// Bus master model standing on the backplane side of the decoder.
// Assumes a level strobe held until acknowledge, two idle edges between cycles.
`timescale 1ns/100ps
`default_nettype none
module siosad_host_model (
  input  wire logic                          sys_clk_i,
  input  wire logic                          ack_i,
  input  wire logic                          data_oe_n_i,
  input  wire logic [siosad_pkg::DATA_W-1:0] rdata_i,
  output logic      [siosad_pkg::ADDR_W-1:0] addr_o,
  output logic      [siosad_pkg::AM_W-1:0]   am_o,
  output logic                               strobe_o,
  output logic                               write_o,
  output logic      [siosad_pkg::DATA_W-1:0] wdata_o
);
  initial begin
    addr_o   = 16'hffff;
    am_o     = 6'h00;
    strobe_o = 1'b0;
    write_o  = 1'b0;
    wdata_o  = 16'h0000;
  end
  // Callers read the converter before any start convert and never loop a
  // freshly written channel back through it
  task automatic cycle(input logic [15:0] a, input logic [5:0] m, input logic w, input logic [15:0] d,
                       output logic acked, output logic drove, output logic [15:0] q);
    acked = 1'b0;
    drove = 1'b0;
    q     = 16'h0000;
    @(posedge sys_clk_i);
    addr_o   <= a;
    am_o     <= m;
    write_o  <= w;
    wdata_o  <= d;
    strobe_o <= 1'b1;
    for (int i = 0; i < 6 && !acked; i++) begin
      @(posedge sys_clk_i);
      if (data_oe_n_i === 1'b0) drove = 1'b1;
      if (ack_i === 1'b1) begin
        acked = 1'b1;
        q     = rdata_i;
      end
    end
    // Released lines show the inverse so stale values never pass for live ones
    addr_o   <= ~a;
    am_o     <= ~m;
    wdata_o  <= ~d;
    strobe_o <= 1'b0;
    @(posedge sys_clk_i);
  endtask
endmodule // siosad_host_model
`default_nettype wire

//--- sim/tb_siosad_top.sv
// Self-checking bench for the short I/O decoder and its register window.
// Assumes the host model in sim/ and the design package.
`timescale 1ns/100ps
`default_nettype none
module tb_siosad_top;
  logic        sys_clk_i;
  logic        reset_n_i;
  logic [7:0]  upper_j;
  logic        low_j;
  logic        priv_j;
  logic [15:0] adc_d;
  wire  [15:0] addr, wdata, rdata, ctrl;
  wire  [5:0]  am;
  wire         strobe, wr, oe_n, ack;
  int          err_count = 0;
  int          n_checks = 0;
  localparam logic [5:0] SUP = siosad_pkg::AM_SHORT_SUPER;
  localparam logic [5:0] NPR = siosad_pkg::AM_SHORT_NONPRV;

  siosad_top uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .addr_i(addr), .am_i(am),
    .strobe_i(strobe), .write_i(wr), .wdata_i(wdata), .upper_base_address_jumpers_i(upper_j),
    .low_base_address_jumper_i(low_j), .privilege_select_jumper_i(priv_j), .adc_data_i(adc_d),
    .rdata_o(rdata), .data_oe_n_o(oe_n), .ack_o(ack), .control_status_word_o(ctrl));
  siosad_host_model host (.sys_clk_i(sys_clk_i), .ack_i(ack), .data_oe_n_i(oe_n), .rdata_i(rdata),
    .addr_o(addr), .am_o(am), .strobe_o(strobe), .write_o(wr), .wdata_o(wdata));

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // Claimed reads drive data; refused cycles neither acknowledge nor drive
  task automatic xfer(input logic [15:0] a, input logic [5:0] m, input logic w, input logic [15:0] d,
                      input logic claim, output logic [15:0] q);
    logic acked, drove;
    host.cycle(a, m, w, d, acked, drove, q);
    chk(acked === claim && drove === (claim & ~w), "claim or drive");
  endtask

  task automatic t_factory;
    logic [15:0] q;
    chk(ack === 1'b0 && oe_n === 1'b1 && ctrl === 16'h0000, "reset state");
    xfer(16'h0000, SUP, 1'b0, 16'h0000, 1'b1, q);
    chk(q === siosad_pkg::BOARD_ID_VAL, "board id");
    xfer(16'h0000, NPR, 1'b0, 16'h0000, 1'b0, q);
    xfer(16'h0004, SUP, 1'b0, 16'h0000, 1'b1, q);
    chk(q === 16'h3c5a, "converter word");
    xfer(16'h0006, SUP, 1'b0, 16'h0000, 1'b1, q);
    chk(q === 16'h0000, "reserved word");
    $display("test factory done");
  endtask
  task automatic t_ctrl;
    logic [15:0] q;
    xfer(16'h0002, SUP, 1'b1, 16'h7840, 1'b1, q);
    chk(ctrl === 16'h7840, "control output");
    xfer(16'h0003, SUP, 1'b0, 16'h0000, 1'b1, q);
    chk(q === 16'h7840, "control readback");
    $display("test control done");
  endtask
  task automatic t_chan;
    logic [15:0] q;
    for (int i = 0; i < 32; i++) begin
      xfer(16'h0040 + 16'(2 * i), SUP, 1'b1, 16'h0a00 + 16'(i), 1'b1, q);
    end
    for (int i = 0; i < 32; i++) begin
      xfer(16'h0040 + 16'(2 * i), SUP, 1'b0, 16'h0000, 1'b1, q);
      chk(q === 16'h0a00 + 16'(i), "channel readback");
    end
    $display("test channels done");
  endtask
  task automatic t_base;
    logic [15:0] q;
    @(posedge sys_clk_i);
    upper_j <= 8'ha5;
    low_j   <= 1'b1;
    priv_j  <= 1'b0;
    xfer(16'ha582, NPR, 1'b1, 16'h1234, 1'b1, q);
    chk(ctrl === 16'h1234, "moved control");
    xfer(16'h0002, NPR, 1'b1, 16'h5555, 1'b0, q);
    xfer(16'ha502, NPR, 1'b1, 16'h5555, 1'b0, q);
    xfer(16'h2582, NPR, 1'b1, 16'h5555, 1'b0, q);
    xfer(16'ha582, SUP, 1'b1, 16'h5555, 1'b0, q);
    chk(ctrl === 16'h1234, "refused write kept out");
    xfer(16'ha5fe, NPR, 1'b0, 16'h0000, 1'b1, q);
    chk(q === 16'h0a1f, "last channel at moved base");
    $display("test base done");
  endtask

  initial begin
    reset_n_i = 1'b0;
    upper_j   = 8'h00;
    low_j     = 1'b0;
    priv_j    = 1'b1;
    adc_d     = 16'h3c5a;
    repeat (20) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    @(posedge sys_clk_i);
    #1;
    t_factory();
    t_ctrl();
    t_chan();
    t_base();
    report_and_stop();
  end
  // About 350 cycles are needed; the limit leaves a wide margin
  initial begin
    #(50 * 5000);
    err_count++;
    report_and_stop();
  end
endmodule // tb_siosad_top
`default_nettype wire
